// ==== design/usc_consts.vh ====
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH
`define USC_CODE_UNCONF   2'h0
`define USC_CODE_SDP      2'h1
`define USC_CODE_CHARGER  2'h2
`define USC_CODE_SUSPEND  2'h3
`define USC_TYPE_NONE     2'h0
`define USC_TYPE_SDP      2'h1
`define USC_TYPE_CDP      2'h2
`define USC_TYPE_DCP      2'h3
`define USC_LED_NS        50000000
`define USC_CLK_MHZ       250
`define USC_LED_CYCLES    ((`USC_LED_NS / 1000) * `USC_CLK_MHZ)
`define USC_DET_NS        1000
`define USC_DET_CYCLES    ((`USC_DET_NS * `USC_CLK_MHZ) / 1000)
`define USC_ST_NOPWR      2'h0
`define USC_ST_DETECT     2'h1
`define USC_ST_READY      2'h2
`endif

// ==== design/usc_status_pins.v ====
`include "usc_consts.vh"
`default_nettype none
module usc_status_pins #(
   parameter LED_CYCLES = `USC_LED_CYCLES,
   parameter DET_CYCLES = `USC_DET_CYCLES,
   parameter [7:0] CODE_MAP = {`USC_CODE_SUSPEND, `USC_CODE_CHARGER,
                               `USC_CODE_SDP, `USC_CODE_UNCONF}
) (
   input  wire       mclk_in,
   input  wire       sys_rst_in,
   input  wire       bus_power_in,
   input  wire       detect_done_in,
   input  wire [1:0] detect_type_in,
   input  wire       link_suspended_in,
   input  wire       configured_in,
   input  wire       wake_in,
   input  wire       remote_wake_allowed_in,
   input  wire       rs485_mode_in,
   input  wire       tx_char_avail_in,
   input  wire       usb_rx_event_in,
   input  wire       usb_tx_event_in,
   input  wire       uart_txd_src_in,
   input  wire       uart_rts_src_in,
   input  wire       cts_n_in,
   input  wire       rxd_in,
   output reg        detect_start_out,
   output reg        charger_code_bit0_out,
   output reg        charger_code_bit1_out,
   output reg        usb_positive_data_line_pullup_out,
   output reg        suspend_out,
   output reg        resume_request_out,
   output reg        remote_wakeup_out,
   output reg        rs485_drive_enable_out,
   output reg        receive_activity_led_n_out,
   output reg        transmit_activity_led_n_out,
   output reg        txd_out,
   output reg        rts_n_out,
   output reg        peer_clear_out,
   output reg        rxd_sample_out
);
////////////////////////////////////////////////////////////////////////////////
// Charger detection sequencing.
reg  [1:0]  state_q;
reg  [1:0]  state_d;
reg  [31:0] det_cnt_q;
reg  [31:0] det_cnt_d;
reg  [1:0]  code_sel;
reg  [1:0]  code_d;
reg         pullup_d;
reg         start_d;
wire [31:0] det_last  = DET_CYCLES;
wire        det_ripe  = (det_cnt_q >= det_last);
wire        pullup_ok = (detect_type_in == `USC_TYPE_SDP) ||
                        (detect_type_in == `USC_TYPE_CDP);

always @* begin
   case (detect_type_in)
      `USC_TYPE_SDP: code_sel = CODE_MAP[3:2];
      `USC_TYPE_CDP: code_sel = CODE_MAP[5:4];
      `USC_TYPE_DCP: code_sel = CODE_MAP[5:4];
      default:       code_sel = CODE_MAP[1:0];
   endcase
end

// Code pins move only on detection end or power loss, never mid-detection.
always @* begin
   state_d = state_q;
   det_cnt_d = det_cnt_q;
   code_d = {charger_code_bit1_out, charger_code_bit0_out};
   pullup_d = usb_positive_data_line_pullup_out;
   start_d = 1'b0;
   if (!bus_power_in) begin
      state_d = `USC_ST_NOPWR;
      code_d = CODE_MAP[1:0];
      pullup_d = 1'b0;
   end else begin
      case (state_q)
         `USC_ST_NOPWR: begin
            state_d = `USC_ST_DETECT;
            start_d = 1'b1;
            det_cnt_d = 32'h0;
         end
         `USC_ST_DETECT: begin
            if (!det_ripe) begin
               det_cnt_d = det_cnt_q + 32'h1;
            end
            // An early done flag is ignored: the detector lines have not
            // settled yet, so the reported type cannot be trusted.
            if (detect_done_in && det_ripe) begin
               state_d = `USC_ST_READY;
               code_d = code_sel;
               pullup_d = pullup_ok;
            end
         end
         `USC_ST_READY: begin
            state_d = `USC_ST_READY;
         end
         default: begin
            state_d = `USC_ST_NOPWR;
         end
      endcase
   end
end

always @(posedge mclk_in) begin
   if (sys_rst_in) begin
      state_q <= `USC_ST_NOPWR;
      det_cnt_q <= 32'h0;
      detect_start_out <= 1'b0;
      charger_code_bit0_out <= 1'b0;
      charger_code_bit1_out <= 1'b0;
      usb_positive_data_line_pullup_out <= 1'b0;
   end else begin
      state_q <= state_d;
      det_cnt_q <= det_cnt_d;
      detect_start_out <= start_d;
      charger_code_bit0_out <= code_d[0];
      charger_code_bit1_out <= code_d[1];
      usb_positive_data_line_pullup_out <= pullup_d;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Wake is edge detected so a held level yields one resume and, when remote wake is allowed, one wakeup.
reg         wake_q;

always @(posedge mclk_in) begin
   if (sys_rst_in) begin
      wake_q <= 1'b0;
      suspend_out <= 1'b1;
      resume_request_out <= 1'b0;
      remote_wakeup_out <= 1'b0;
   end else begin
      wake_q <= wake_in;
      suspend_out <= link_suspended_in || !configured_in;
      resume_request_out <= 1'b0;
      remote_wakeup_out <= resume_request_out && remote_wake_allowed_in;
      if (wake_in && !wake_q && link_suspended_in) begin
         resume_request_out <= 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Activity lamps: channel 0 follows USB receive, channel 1 USB transmit.
// Stretching makes single-packet activity visible to the eye.
wire [31:0] led_len   = LED_CYCLES;
wire [1:0]  led_event = {usb_tx_event_in, usb_rx_event_in};
wire [1:0]  led_lit;
genvar      ch;

generate
   for (ch = 0; ch < 2; ch = ch + 1) begin : g_led
      reg [31:0] hold_q;
      reg [31:0] hold_d;

      always @* begin
         hold_d = hold_q;
         if (led_event[ch]) begin
            hold_d = led_len;
         end else if (hold_q != 32'h0) begin
            hold_d = hold_q - 32'h1;
         end
      end

      always @(posedge mclk_in) begin
         if (sys_rst_in) begin
            hold_q <= 32'h0;
         end else begin
            hold_q <= hold_d;
         end
      end

      assign led_lit[ch] = led_event[ch] || (hold_q > 32'h1);
   end
endgenerate

always @(posedge mclk_in) begin
   if (sys_rst_in) begin
      receive_activity_led_n_out <= 1'b1;
      transmit_activity_led_n_out <= 1'b1;
   end else begin
      receive_activity_led_n_out <= !led_lit[0];
      transmit_activity_led_n_out <= !led_lit[1];
   end
end

////////////////////////////////////////////////////////////////////////////////
// Outside RS485 mode the enable stays low, so a point-to-point link is never
// driven as if it were a shared bus.
always @(posedge mclk_in) begin
   if (sys_rst_in) begin
      rs485_drive_enable_out <= 1'b0;
   end else begin
      rs485_drive_enable_out <= rs485_mode_in && tx_char_avail_in;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Pass-through pins are registered so every output leaves a flip-flop; the
// price is one cycle of latency on each data and handshake line.
always @(posedge mclk_in) begin
   if (sys_rst_in) begin
      txd_out <= 1'b1;
      rts_n_out <= 1'b1;
      peer_clear_out <= 1'b0;
      rxd_sample_out <= 1'b1;
   end else begin
      txd_out <= uart_txd_src_in;
      rts_n_out <= uart_rts_src_in;
      peer_clear_out <= !cts_n_in;
      rxd_sample_out <= rxd_in;
   end
end

endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 0, sys_rst_in = 1, bus_power_in = 0, detect_done_in = 0, wake_go = 0;
   logic link_suspended_in = 0, configured_in = 0, remote_wake_allowed_in = 0, slow = 0;
   logic rs485_mode_in = 0, tx_char_avail_in = 0, usb_rx_event_in = 0, usb_tx_event_in = 0;
   logic uart_txd_src_in = 1, uart_rts_src_in = 1, slow_p = 0;
   logic [2:0] txd_h = 3'h7, rts_h = 3'h7;
   logic [1:0] detect_type_in = 0;
   wire logic cts_n_in, rxd_in, wake_in, detect_start_out, charger_code_bit0_out, suspend_out;
   wire logic charger_code_bit1_out, usb_positive_data_line_pullup_out, resume_request_out;
   wire logic remote_wakeup_out, rs485_drive_enable_out, receive_activity_led_n_out, txd_out;
   wire logic transmit_activity_led_n_out, rts_n_out, peer_clear_out, rxd_sample_out;
   wire logic [2:0] cp = {charger_code_bit1_out, charger_code_bit0_out,
                          usb_positive_data_line_pullup_out};
   int seed = 32'h8d61, n_fail = 0, num_checks = 0;
   always #2 mclk_in = ~mclk_in;
   usc_status_pins #(.LED_CYCLES(10), .DET_CYCLES(2)) dut_u (.*);
   usc_mcu_model peer_u (.clk(mclk_in), .rst(sys_rst_in), .rts_n(rts_n_out), .txd(txd_out),
      .sus(suspend_out), .slow(slow), .go(wake_go), .cts_n(cts_n_in), .rxd(rxd_in),
      .wake(wake_in));
   function logic [2:0] want(input logic [1:0] t);
      return t == 2'h0 ? 3'h0 : t == 2'h1 ? 3'h3 : t == 2'h2 ? 3'h5 : 3'h4;
   endfunction
   // Inputs move 1 ns after the edge so they never race the design's sampling.
   task step;
      @(posedge mclk_in);
      #1;
   endtask
   task summarize;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input bit ok, input string m);
      num_checks++;
      if (!ok) begin
         n_fail++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task need(input bit ok, input string m);
      chk(ok, m);
      if (!ok) summarize;
   endtask
   initial begin
      repeat (12) step;
      sys_rst_in = 0;
      step;
      for (int t = 0; t < 4; t++) begin
         bus_power_in = 1;
         for (int i = 0; i < 4 && detect_start_out !== 1'b1; i++) step;
         need(detect_start_out === 1'b1, "no start");
         repeat (3) step;
         {detect_done_in, detect_type_in} = {1'b1, 2'(t)};
         step;
         detect_done_in = 0;
         step;
         chk(cp === want(detect_type_in), "code");
         bus_power_in = 0;
         repeat (2) step;
         chk(cp === 3'h0, "loss");
      end
      $display("detect done");
      for (int i = 0; i < 200; i++) begin
         txd_h = {txd_h[1:0], uart_txd_src_in};
         rts_h = {rts_h[1:0], uart_rts_src_in};
         slow_p = slow;
         {link_suspended_in, configured_in, rs485_mode_in, tx_char_avail_in, usb_rx_event_in,
          usb_tx_event_in, uart_txd_src_in, uart_rts_src_in, slow} = 9'($random(seed));
         step;
         chk(suspend_out === (link_suspended_in | ~configured_in), "susp");
         chk(rs485_drive_enable_out === (rs485_mode_in & tx_char_avail_in), "485");
         chk({txd_out, rts_n_out} === {uart_txd_src_in, uart_rts_src_in}, "uart");
         chk(rxd_sample_out === txd_h[1], "rxd");
         chk(peer_clear_out === !(slow_p ? rts_h[2] : rts_h[1]), "cts");
         chk(!usb_rx_event_in || receive_activity_led_n_out === 1'b0, "rx led");
         chk(!usb_tx_event_in || transmit_activity_led_n_out === 1'b0, "tx led");
      end
      {usb_rx_event_in, usb_tx_event_in} = 2'h0;
      repeat (12) step;
      chk({receive_activity_led_n_out, transmit_activity_led_n_out} === 2'h3, "led");
      $display("random done");
      {link_suspended_in, configured_in, remote_wake_allowed_in} = 3'h7;
      repeat (3) step;
      wake_go = 1;
      for (int i = 0; i < 8 && remote_wakeup_out !== 1'b1; i++) step;
      need(remote_wakeup_out === 1'b1, "no wakeup");
      wake_go = 0;
      $display("wake done");
      summarize;
   end
endmodule
`default_nettype wire

// ==== testbench/usc_mcu_model.sv ====
`default_nettype none
module usc_mcu_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic rts_n,
   input wire logic txd,
   input wire logic sus,
   input wire logic slow,
   input wire logic go,
   output var logic cts_n,
   output var logic rxd,
   output var logic wake
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lag_q;
   // A slow controller grants a cycle late, as a busy firmware loop would.
   always @(posedge clk) begin
      lag_q <= rts_n;
      cts_n <= rst | (slow ? lag_q : rts_n);
      rxd <= rst | txd;
      wake <= !rst & go & sus;
   end
endmodule
`default_nettype wire

// ==== testbench/usc_status_monitor.sv ====
`default_nettype none
module usc_status_monitor (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic bus_power_in,
   input wire logic detect_done_in,
   input wire logic link_suspended_in,
   input wire logic configured_in,
   input wire logic wake_in,
   input wire logic rs485_mode_in,
   input wire logic tx_char_avail_in,
   input wire logic usb_rx_event_in,
   input wire logic detect_start_out,
   input wire logic charger_code_bit0_out,
   input wire logic charger_code_bit1_out,
   input wire logic suspend_out,
   input wire logic usb_positive_data_line_pullup_out,
   input wire logic resume_request_out,
   input wire logic rs485_drive_enable_out,
   input wire logic receive_activity_led_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [1:0] code = {charger_code_bit1_out, charger_code_bit0_out};
   wire logic       pu = usb_positive_data_line_pullup_out;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   AST_START: assert property ($rose(bus_power_in) |=> detect_start_out)
      else $error("start");
   AST_LOSS: assert property (!bus_power_in |=> code == 2'h0 && !pu)
      else $error("loss");
   AST_PULL: assert property (pu |-> code == 2'h1 || code == 2'h2)
      else $error("pull");
   AST_SUSP: assert property (link_suspended_in || !configured_in |=> suspend_out)
      else $error("susp");
   AST_RS485: assert property (rs485_mode_in && tx_char_avail_in
      |=> rs485_drive_enable_out) else $error("rs485");
   AST_WAKE: assert property ($rose(wake_in) && link_suspended_in |=> resume_request_out)
      else $error("wake");
   AST_STABLE: assert property (bus_power_in && !detect_done_in
      && !$past(detect_done_in) |=> $stable(code)) else $error("stable");
   AST_LED: assert property (usb_rx_event_in |-> ##[1:2] !receive_activity_led_n_out)
      else $error("led");
   cover property (pu);
   cover property (resume_request_out);
   cover property (rs485_drive_enable_out);
endmodule
bind usc_status_pins usc_status_monitor mon_u (.*);
`default_nettype wire
